// ---- src/frc_map.vh ----
`ifndef FRC_MAP_VH
`define FRC_MAP_VH
// register byte addresses
`define FRC_ADDR_CTRL 8'h00
`define FRC_ADDR_IRQ_STATUS 8'h04
`define FRC_ADDR_IRQ_MASK 8'h08
`define FRC_ADDR_PIN 8'h0C
// control field positions
`define FRC_BIT_ENABLE 7
`define FRC_BIT_READY 6
`define FRC_BIT_PASS 5
`define FRC_BIT_SRC_HI 4
`define FRC_BIT_SRC_LO 3
`define FRC_BIT_BUF_EN 0
// control write mask: ready and bits 2:1 are not writable
`define FRC_CTRL_WMASK 8'hB9
`define FRC_CTRL_RESET 8'h00
// buffer source codes
`define FRC_SRC_BANDGAP 2'h0
`define FRC_SRC_DAC 2'h1
`define FRC_SRC_OPAMP 2'h2
`define FRC_SRC_EXTIN 2'h3
// interrupt status bits
`define FRC_IRQ_READY_RISE 0
`define FRC_IRQ_READY_FALL 1
// stabilization time in ns and cycles at 20 ns period
`define FRC_STAB_NS 25000
`define FRC_CLK_NS 20
`define FRC_STAB_CYCLES ((`FRC_STAB_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS)
// axi responses
`define FRC_RESP_OKAY 2'h0
`define FRC_RESP_SLVERR 2'h2
`endif

// ---- src/frc_settle_timer.v ----
`timescale 1ns/1ps
`include "frc_map.vh"
module frc_settle_timer #(
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] CYCLES = `FRC_STAB_CYCLES
)
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // control
  input wire powered,
  // status
  output wire ready
);
  reg [WIDTH-1:0] count_q;
  reg ready_q;

  // counts while powered, ready once the count reaches the settle time
  always @(posedge clk)
  begin
    if (sys_rst || !powered)
    begin
      count_q <= {WIDTH{1'b0}};
      ready_q <= 1'b0;
    end
    else if (count_q >= CYCLES - 1'b1)
    begin
      ready_q <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 1'b1;
    end
  end

  assign ready = ready_q;
endmodule

// ---- src/frc_pin_mux.v ----
`timescale 1ns/1ps
module frc_pin_mux (
  // configuration
  input wire [1:0] srcSel,
  input wire bufEnable,
  input wire refReady,
  // analog source requests
  output wire [3:0] srcRoute,
  // pin digital side
  input wire pinDigIn,
  input wire pinDigOut,
  input wire pinDigOe,
  output wire pinIn,
  output wire pinOut,
  output wire pinOe,
  output wire analogOut
);
  wire [3:0] srcOneHot;

  // one-hot source routing gated by the buffer enable
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : gen_route
      assign srcOneHot[i] = (srcSel == i[1:0]);
      assign srcRoute[i] = srcOneHot[i] & bufEnable;
    end
  endgenerate

  // analog output overrides digital in and out
  assign analogOut = bufEnable & refReady;
  assign pinIn = bufEnable ? 1'b0 : pinDigIn;
  assign pinOut = bufEnable ? 1'b0 : pinDigOut;
  assign pinOe = bufEnable ? 1'b0 : pinDigOe;
endmodule

// ---- src/frc_reference_control.v ----
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "frc_map.vh"
module frc_reference_control #(
  parameter SHUNT_VARIANT = 0,
  parameter STAB_WIDTH = 16,
  parameter [STAB_WIDTH-1:0] STAB_CYCLES = `FRC_STAB_CYCLES
)
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // sleep status, retention only
  input wire sleepWake,
  // analog control
  output wire referencePower,
  output wire outputPassGate,
  output wire [3:0] bufferSourceRoute,
  output wire referenceDrive,
  // output pin digital side
  input wire pinDigIn,
  input wire pinDigOut,
  input wire pinDigOe,
  output wire pinIn,
  output wire pinOut,
  output wire pinOe,
  // interrupt
  output wire irq
);
  reg [7:0] ctrl_q;
  reg [1:0] irqStatus_q;
  reg [1:0] irqMask_q;
  reg [7:0] awAddr_q;
  reg awHave_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg wHave_q;
  reg bValid_q;
  reg [1:0] bResp_q;
  reg rValid_q;
  reg [31:0] rData_q;
  reg [1:0] rResp_q;
  reg readyPrev_q;
  wire refEnabled;
  wire refReady;
  wire [7:0] ctrlView;
  wire doWrite;
  wire doRead;
  wire readStatus;
  wire [1:0] irqEvent;
  wire bufferOn;

  // true when a byte address names a mapped register
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `FRC_ADDR_CTRL) || (addr == `FRC_ADDR_IRQ_STATUS) ||
        (addr == `FRC_ADDR_IRQ_MASK) || (addr == `FRC_ADDR_PIN);
    end
  endfunction

  // reference power from enable bit or shunt variant
  assign refEnabled = ctrl_q[`FRC_BIT_ENABLE] | (SHUNT_VARIANT != 0);
  assign referencePower = refEnabled;

  // stabilization timer
  frc_settle_timer #(
    .WIDTH(STAB_WIDTH),
    .CYCLES(STAB_CYCLES)
  ) uSettle (
    .clk(clk),
    .sys_rst(sys_rst),
    .powered(refEnabled),
    .ready(refReady)
  );

  // readback view with live ready flag and zero unimplemented bits
  assign ctrlView = {ctrl_q[7], refReady, ctrl_q[5:3], 2'b00, ctrl_q[0]};

  // pin buffer and source routing
  assign bufferOn = ctrl_q[`FRC_BIT_BUF_EN];
  assign outputPassGate = ctrl_q[`FRC_BIT_PASS];
  frc_pin_mux uPin (
    .srcSel(ctrl_q[`FRC_BIT_SRC_HI:`FRC_BIT_SRC_LO]),
    .bufEnable(bufferOn),
    .refReady(1'b1),
    .srcRoute(bufferSourceRoute),
    .pinDigIn(pinDigIn),
    .pinDigOut(pinDigOut),
    .pinDigOe(pinDigOe),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .analogOut(referenceDrive)
  );

  // write channel handshakes
  assign s_axi_awready = !awHave_q && !bValid_q;
  assign s_axi_wready = !wHave_q && !bValid_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign doWrite = awHave_q && wHave_q && !bValid_q;

  // capture address and data in either order, answer once both held
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      awAddr_q <= 8'h00;
      awHave_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      wHave_q <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q <= `FRC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_q <= s_axi_awaddr;
        awHave_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHave_q <= 1'b1;
      end
      if (doWrite)
      begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q <= mapped(awAddr_q) ? `FRC_RESP_OKAY : `FRC_RESP_SLVERR;
      end
      else if (bValid_q && s_axi_bready)
      begin
        bValid_q <= 1'b0;
      end
    end
  end

  // control register, cleared only by reset and untouched by wake
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_q <= `FRC_CTRL_RESET;
      irqMask_q <= 2'b00;
    end
    else if (doWrite && wStrb_q[0])
    begin
      if (awAddr_q == `FRC_ADDR_CTRL)
      begin
        ctrl_q <= wData_q[7:0] & `FRC_CTRL_WMASK;
      end
      else if (awAddr_q == `FRC_ADDR_IRQ_MASK)
      begin
        irqMask_q <= wData_q[1:0];
      end
    end
  end

  // read channel
  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign doRead = s_axi_arvalid && !rValid_q;
  assign readStatus = doRead && (s_axi_araddr == `FRC_ADDR_IRQ_STATUS);

  // read data captured when the address is taken
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rValid_q <= 1'b0;
      rData_q <= 32'h00000000;
      rResp_q <= `FRC_RESP_OKAY;
    end
    else if (doRead)
    begin
      rValid_q <= 1'b1;
      rResp_q <= `FRC_RESP_OKAY;
      if (s_axi_araddr == `FRC_ADDR_CTRL)
      begin
        rData_q <= {24'h000000, ctrlView};
      end
      else if (s_axi_araddr == `FRC_ADDR_IRQ_STATUS)
      begin
        rData_q <= {30'h00000000, irqStatus_q};
      end
      else if (s_axi_araddr == `FRC_ADDR_IRQ_MASK)
      begin
        rData_q <= {30'h00000000, irqMask_q};
      end
      else if (s_axi_araddr == `FRC_ADDR_PIN)
      begin
        rData_q <= {31'h00000000, pinIn};
      end
      else
      begin
        rData_q <= 32'h00000000;
        rResp_q <= `FRC_RESP_SLVERR;
      end
    end
    else if (rValid_q && s_axi_rready)
    begin
      rValid_q <= 1'b0;
    end
  end

  // ready edges set sticky status; a read clears, a new event wins
  assign irqEvent = {readyPrev_q & ~refReady, ~readyPrev_q & refReady};
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      readyPrev_q <= 1'b0;
      irqStatus_q <= 2'b00;
    end
    else
    begin
      readyPrev_q <= refReady;
      irqStatus_q <= (readStatus ? 2'b00 : irqStatus_q) | irqEvent;
    end
  end

  // level interrupt from unmasked status
  assign irq = |(irqStatus_q & irqMask_q);

  // sleep wake carries no register effect
  wire unusedWake = sleepWake;
endmodule

// ---- tb/frc_ref_checker.sv ----
`timescale 1ns/1ps
module frc_ref_checker #(
  parameter STAB_WIDTH = 16,
  parameter [STAB_WIDTH-1:0] STAB_CYCLES = 4
)
(
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // register bus
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_bvalid,
  // analog control
  input logic referencePower,
  input logic outputPassGate,
  input logic [3:0] bufferSourceRoute,
  input logic referenceDrive,
  // pin digital side
  input logic pinDigIn,
  input logic pinDigOut,
  input logic pinDigOe,
  input logic pinIn,
  input logic pinOut,
  input logic pinOe,
  input logic irq
);
  logic [15:0] pwrCnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // cycles the reference has been powered, saturating
  always @(posedge clk)
    pwrCnt_q <= (sys_rst || !referencePower) ? 16'h0000 : pwrCnt_q + (pwrCnt_q != 16'hFFFF);
  a_pin_blocked: assert property (referenceDrive |-> !(pinIn || pinOut || pinOe))
    else $error("pin digital side active while driving reference");
  a_pin_pass: assert property (!referenceDrive |-> {pinIn, pinOut, pinOe} == {pinDigIn, pinDigOut, pinDigOe})
    else $error("pin digital side not passed through");
  a_route_gated: assert property (!referenceDrive |-> bufferSourceRoute == 4'h0)
    else $error("source routed with buffer off");
  a_route_onehot: assert property (referenceDrive |-> $onehot(bufferSourceRoute))
    else $error("source route not one-hot");
  // control outputs move only with a write response, never on wake
  a_ctrl_stable: assert property (!$stable({referencePower, referenceDrive, outputPassGate, bufferSourceRoute}) |-> $rose(s_axi_bvalid))
    else $error("control output changed without a write");
  // non-shunt build assumed by the bench
  a_reset_clears: assert property (disable iff (1'b0) sys_rst |=> !(referencePower || referenceDrive || outputPassGate || irq))
    else $error("outputs not cleared by reset");
  a_ready_wait: assert property (s_axi_rvalid && s_axi_rdata[6] |-> pwrCnt_q >= STAB_CYCLES)
    else $error("ready flag read before settle time");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  c_drive: cover property (referenceDrive);
  c_ready: cover property (s_axi_rvalid && s_axi_rdata[6]);
  c_irq: cover property ($rose(irq));
endmodule
bind frc_reference_control frc_ref_checker #(.STAB_WIDTH(STAB_WIDTH), .STAB_CYCLES(STAB_CYCLES)) i_frc_ref_checker (.*);

// ---- tb/frc_reference_control_tb.sv ----
`timescale 1ns/1ps
`include "frc_map.vh"
module frc_reference_control_tb;
  logic clk = 0;
  logic sys_rst = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, sleepWake = 0, pinDigIn = 0, pinDigOut = 0, pinDigOe = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire referencePower, outputPassGate, referenceDrive, pinIn, pinOut, pinOe, irq;
  wire [3:0] bufferSourceRoute;
  int err_total = 0, checked = 0, cycles = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  frc_reference_control #(.STAB_CYCLES(16'h0004)) i_frc_reference_control (.*);
  initial forever #10 clk = ~clk;
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    begin
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checked++;
      if (seen !== exp)
      begin
        err_total++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tr;
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(negedge clk);
        ta = s_axi_awvalid && s_axi_awready;
        tw = s_axi_wvalid && s_axi_wready;
        tr = s_axi_bvalid;
        rs = s_axi_bresp;
        @(posedge clk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
      end while (!tr);
      s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ta, tr;
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(negedge clk);
        ta = s_axi_arvalid && s_axi_arready;
        tr = s_axi_rvalid;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge clk);
        if (ta) s_axi_arvalid <= 1'b0;
      end while (!tr);
      s_axi_rready <= 1'b0;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    begin
      rdr(a);
      chk(rd, e);
      chk(rs, `FRC_RESP_OKAY);
    end
  endtask
  task automatic tReset;
    begin
      rdc(`FRC_ADDR_CTRL, 0);
      rdc(`FRC_ADDR_IRQ_MASK, 0);
      rdc(`FRC_ADDR_IRQ_STATUS, 0);
      chk({referencePower, referenceDrive, outputPassGate, bufferSourceRoute}, 0);
      $display("reset test done");
    end
  endtask
  task automatic tSources;
    begin
      pinDigIn <= 1'b1;
      pinDigOut <= 1'b1;
      pinDigOe <= 1'b1;
      for (int s = 0; s < 4; s++)
      begin
        wr(`FRC_ADDR_CTRL, {3'h0, s[1:0], 3'h1});
        chk(bufferSourceRoute, 32'h1 << s);
        chk({pinIn, pinOut, pinOe}, 0);
        rdc(`FRC_ADDR_PIN, 0);
      end
      wr(`FRC_ADDR_CTRL, 8'h08);
      chk(bufferSourceRoute, 0);
      chk({pinIn, pinOut, pinOe}, 3'h7);
      rdc(`FRC_ADDR_PIN, 1);
      wr(`FRC_ADDR_CTRL, 8'h7F);
      rdc(`FRC_ADDR_CTRL, 8'h39);
      chk({referencePower, outputPassGate}, 2'h1);
      $display("source test done");
    end
  endtask
  task automatic tReady;
    begin
      wr(`FRC_ADDR_IRQ_MASK, 8'h01);
      wr(`FRC_ADDR_CTRL, 8'h80);
      chk(referencePower, 1);
      rdc(`FRC_ADDR_CTRL, 8'h80);
      chk(irq, 0);
      repeat (8) @(posedge clk);
      rdc(`FRC_ADDR_CTRL, 8'hC0);
      chk(irq, 1);
      rdc(`FRC_ADDR_IRQ_STATUS, 1);
      rdc(`FRC_ADDR_IRQ_STATUS, 0);
      chk(irq, 0);
      wr(`FRC_ADDR_CTRL, 8'h00);
      repeat (3) @(posedge clk);
      rdc(`FRC_ADDR_CTRL, 0);
      chk(irq, 0);
      rdc(`FRC_ADDR_IRQ_STATUS, 2);
      $display("ready test done");
    end
  endtask
  task automatic tSleep;
    begin
      wr(`FRC_ADDR_CTRL, 8'hA9);
      sleepWake <= 1'b1;
      repeat (8) @(posedge clk);
      sleepWake <= 1'b0;
      rdc(`FRC_ADDR_CTRL, 8'hE9);
      // software parks the reference before a second sleep
      wr(`FRC_ADDR_CTRL, 8'h00);
      sleepWake <= 1'b1;
      repeat (4) @(posedge clk);
      sleepWake <= 1'b0;
      rdc(`FRC_ADDR_CTRL, 0);
      chk(referencePower, 0);
      wr(`FRC_ADDR_CTRL, 8'hA9);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(`FRC_ADDR_CTRL, 0);
      chk({referencePower, referenceDrive, bufferSourceRoute}, 0);
      rdr(8'h10);
      chk(rs, `FRC_RESP_SLVERR);
      chk(rd, 32'h0);
      wr(8'h10, 8'hFF);
      chk(rs, `FRC_RESP_SLVERR);
      $display("sleep test done");
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    tReset();
    tSources();
    tReady();
    tSleep();
    print_verdict();
  end
endmodule
